// *** src/bfe_pkg.sv ***
// Shared constants and types for the boot flash and error command block
package bfe_pkg;

   // ==========================================================
   // Command op-codes
   localparam logic [7:0] OP_HIST_RD  = 8'hC1;
   localparam logic [7:0] OP_CLR_STAT = 8'hC2;
   localparam logic [7:0] OP_CLR_HIST = 8'hC3;
   localparam logic [7:0] OP_ERASE    = 8'hE0;
   localparam logic [7:0] OP_PAGE     = 8'hE1;
   localparam logic [7:0] OP_VERIFY   = 8'hE2;
   localparam logic [7:0] OP_RATE_WR  = 8'hE3;
   localparam logic [7:0] OP_RATE_RD  = 8'hE4;

   // ==========================================================
   // Signature, padding and lengths
   localparam logic [31:0] SIG_WORD      = 32'hDDCCBBAA;
   localparam logic [7:0]  PAD_BYTE      = 8'hFF;
   localparam logic [8:0]  PAGE_BYTES    = 9'h100;
   localparam logic [8:0]  SIG_LEN       = 9'h004;
   localparam logic [8:0]  RATE_LEN      = 9'h003;
   localparam logic [7:0]  HIST_DEPTH    = 8'h3E;
   localparam logic [7:0]  HIST_RD_BYTES = 8'hF9;
   localparam logic [7:0]  RATE_RD_BYTES = 8'h03;
   localparam logic [7:0]  CAPS_MASK     = 8'h1F;

   // ==========================================================
   // Flash read capability bits and read instructions
   localparam int         CAP_FAST  = 0;
   localparam int         CAP_DO    = 1;
   localparam int         CAP_DIO   = 2;
   localparam int         CAP_QO    = 3;
   localparam int         CAP_QIO   = 4;
   localparam logic [7:0] FL_FAST   = 8'h0B;
   localparam logic [7:0] FL_DUAL_O = 8'h3B;
   localparam logic [7:0] FL_DUAL_IO = 8'hBB;
   localparam logic [7:0] FL_QUAD_O = 8'h6B;
   localparam logic [7:0] FL_QUAD_IO = 8'hEB;

   // ==========================================================
   // Error categories, identifiers and status bits
   localparam logic [3:0]  CAT_SELFTEST = 4'h8;
   localparam logic [3:0]  CAT_OPER     = 4'h4;
   localparam logic [3:0]  CAT_CMD      = 4'h2;
   localparam logic [10:0] ERR_SIG      = 11'h001;
   localparam logic [10:0] ERR_LEN      = 11'h002;
   localparam logic [10:0] ERR_FLASH    = 11'h003;
   localparam logic [10:0] ERR_OPCODE   = 11'h004;
   localparam logic [10:0] ERR_SELFTEST = 11'h005;
   localparam logic [10:0] ERR_OPER     = 11'h006;
   localparam int          STS_RIP      = 1;
   localparam int          STS_RDAV     = 3;

   // ==========================================================
   // Host register map
   localparam logic [7:0] REG_CMD   = 8'h00;
   localparam logic [7:0] REG_PARAM = 8'h04;
   localparam logic [7:0] REG_STAT  = 8'h08;
   localparam logic [7:0] REG_RX    = 8'h0C;
   localparam logic [7:0] REG_IRQ   = 8'h10;
   localparam logic [7:0] REG_MASK  = 8'h14;
   localparam int         CMD_NB_LO = 8;
   localparam int         CMD_SOP   = 16;
   localparam int         CMD_LAST  = 17;
   localparam int         CMD_SIG   = 18;
   localparam int         IRQ_SENT  = 0;
   localparam int         IRQ_RX    = 1;
   localparam int         IRQ_RIPDN = 2;
   localparam int         IRQ_REFUS = 3;

   typedef enum logic [1:0] {FL_NONE, FL_ERASE, FL_PROG, FL_VERIFY} bfe_flop_e;

endpackage

// *** src/bfe_link_if.sv ***
// Command link between the host end and the device end
`timescale 1ns/100ps
interface bfe_link_if (
   input wire logic clk_i
);
   logic        cmd_valid;
   logic        cmd_ready;
   logic        cmd_first;
   logic        cmd_last;
   logic [7:0]  cmd_data;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic [7:0]  status1;
   logic [15:0] status_err;

   modport dev (input cmd_valid, cmd_first, cmd_last, cmd_data,
                output cmd_ready, rsp_valid, rsp_data, status1, status_err);
   modport host (output cmd_valid, cmd_first, cmd_last, cmd_data,
                 input cmd_ready, rsp_valid, rsp_data, status1, status_err);
endinterface

// *** src/bfe_dev.sv ***
// Device end: boot command interpreter for flash and error commands
// ==========================================================
`timescale 1ns/100ps
module bfe_dev #(
   parameter int ADDR_W = 24
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   // Command link
   bfe_link_if.dev                  link,
   // Flash engine
   output logic                     fl_start_o,
   output bfe_pkg::bfe_flop_e       fl_op_o,
   output logic [ADDR_W-1:0]        fl_addr_o,
   output logic                     fl_wvalid_o,
   output logic [7:0]               fl_wdata_o,
   input  wire logic                fl_done_i,
   input  wire logic                fl_fail_i,
   output logic [7:0]               fl_rd_instr_o,
   output logic [15:0]              fl_clk_limit_o,
   // Fault events
   input  wire logic                selftest_fault_i,
   input  wire logic                op_fault_i
);
   import bfe_pkg::*;

   if (ADDR_W < 16 || ADDR_W > 32) begin : g_chk
      $error("bfe_dev: ADDR_W must lie in 16..32");
   end

   // ==========================================================
   // State
   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_FLASH, ST_RSP} bfe_dst_e;

   typedef struct packed {
      bfe_dst_e                     st;
      logic [7:0]                   op;
      logic [8:0]                   cnt;
      logic                         sig_ok;
      logic [7:0]                   caps_in;
      logic [7:0]                   rate_lo;
      logic [4:0]                   caps;
      logic [15:0]                  rate;
      logic [7:0]                   rd_instr;
      logic                         rip;
      logic [3:0]                   errf;
      logic [11:0]                  ecode;
      logic [7:0]                   hcnt;
      logic [HIST_DEPTH-1:0][31:0]  hist;
      logic [ADDR_W-1:0]            addr;
      logic                         fl_start;
      bfe_flop_e                    fl_op;
      logic                         wvalid;
      logic [7:0]                   wdata;
      logic                         rsp_valid;
      logic [7:0]                   rsp_data;
      logic [7:0]                   rcnt;
   } bfe_dev_s;

   bfe_dev_s   r;
   bfe_dev_s   n;
   logic       take;
   logic [8:0] np;
   logic [7:0] opx;
   logic [7:0] ridx;
   logic [7:0] rlen;
   logic [31:0] rword;
   logic [7:0] s1;

   // ==========================================================
   // Error logging
   // Count saturates so a flood of faults never wraps back to a small value
   function automatic bfe_dev_s log_err(input bfe_dev_s s, input logic [3:0] cat,
                                        input logic [10:0] id, input logic [15:0] info);
      bfe_dev_s t;
      t = s;
      t.errf = s.errf | cat;
      t.ecode = {1'b0, id};
      if (s.hcnt < HIST_DEPTH) begin
         t.hist[s.hcnt[5:0]] = {cat, 1'b0, id, info};
      end
      if (s.hcnt != 8'hFF) begin
         t.hcnt = s.hcnt + 8'h01;
      end
      return t;
   endfunction

   function automatic logic [7:0] pick_instr(input logic [4:0] c);
      if (c[CAP_QIO]) begin
         return FL_QUAD_IO;
      end else if (c[CAP_QO]) begin
         return FL_QUAD_O;
      end else if (c[CAP_DIO]) begin
         return FL_DUAL_IO;
      end else if (c[CAP_DO]) begin
         return FL_DUAL_O;
      end
      return FL_FAST;
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      n.fl_start = 1'b0;
      n.wvalid = 1'b0;
      n.rsp_valid = 1'b0;
      take = link.cmd_valid && (r.st == ST_IDLE || r.st == ST_RX);
      np = 9'h000;
      opx = link.cmd_first ? link.cmd_data : r.op;
      ridx = r.rcnt - 8'h01;
      rlen = (r.op == OP_HIST_RD) ? HIST_RD_BYTES : RATE_RD_BYTES;
      rword = r.hist[ridx[7:2]];
      if (take) begin
         if (link.cmd_first) begin
            n.op = link.cmd_data;
            n.cnt = 9'h000;
            n.sig_ok = 1'b1;
            n.st = ST_RX;
         end else begin
            np = (r.cnt == 9'h1FF) ? r.cnt : r.cnt + 9'h001;
            n.cnt = np;
            if (r.cnt < SIG_LEN && link.cmd_data != SIG_WORD[8*r.cnt[1:0] +: 8]) begin
               n.sig_ok = 1'b0;
            end
            if (r.cnt == 9'h000) begin
               n.caps_in = link.cmd_data;
            end
            if (r.cnt == 9'h001) begin
               n.rate_lo = link.cmd_data;
            end
            // Payload streams straight to the flash engine; it commits on start
            if (r.op == OP_PAGE && r.cnt < PAGE_BYTES) begin
               n.wvalid = 1'b1;
               n.wdata = link.cmd_data;
            end
         end
         if (link.cmd_last) begin
            n.st = ST_IDLE;
            case (opx)
               OP_CLR_STAT, OP_CLR_HIST, OP_ERASE: begin
                  if (n.sig_ok && np == SIG_LEN) begin
                     if (opx == OP_ERASE) begin
                        n.addr = '0;
                        n.rip = 1'b1;
                        n.fl_start = 1'b1;
                        n.fl_op = FL_ERASE;
                        n.st = ST_FLASH;
                     end else begin
                        n.errf = 4'h0;
                        n.ecode = 12'h000;
                        if (opx == OP_CLR_HIST) begin
                           n.hcnt = 8'h00;
                           n.hist = '0;
                        end
                     end
                  end else begin
                     n = log_err(n, CAT_CMD, ERR_SIG, {8'h00, opx});
                  end
               end
               OP_PAGE: begin
                  if (np == PAGE_BYTES) begin
                     n.rip = 1'b1;
                     n.fl_start = 1'b1;
                     n.fl_op = FL_PROG;
                     n.st = ST_FLASH;
                  end else begin
                     n = log_err(n, CAT_CMD, ERR_LEN, {7'h00, np});
                  end
               end
               OP_VERIFY: begin
                  if (np == 9'h000) begin
                     n.rip = 1'b1;
                     n.fl_start = 1'b1;
                     n.fl_op = FL_VERIFY;
                     n.st = ST_FLASH;
                  end else begin
                     n = log_err(n, CAT_CMD, ERR_LEN, {7'h00, np});
                  end
               end
               OP_RATE_WR: begin
                  if (np == RATE_LEN) begin
                     n.caps = n.caps_in[4:0];
                     n.rate = {link.cmd_data, n.rate_lo};
                     n.rd_instr = pick_instr(n.caps_in[4:0]);
                  end else begin
                     n = log_err(n, CAT_CMD, ERR_LEN, {7'h00, np});
                  end
               end
               OP_RATE_RD, OP_HIST_RD: begin
                  if (np == 9'h000) begin
                     n.st = ST_RSP;
                     n.rcnt = 8'h00;
                  end else begin
                     n = log_err(n, CAT_CMD, ERR_LEN, {7'h00, np});
                  end
               end
               default: begin
                  n = log_err(n, CAT_CMD, ERR_OPCODE, {8'h00, opx});
               end
            endcase
         end
      end
      case (r.st)
         ST_FLASH: begin
            if (fl_done_i) begin
               n.rip = 1'b0;
               n.st = ST_IDLE;
               if (fl_fail_i) begin
                  n = log_err(n, CAT_CMD, ERR_FLASH, r.addr[15:0]);
               end else if (r.fl_op == FL_PROG) begin
                  n.addr = r.addr + ADDR_W'(PAGE_BYTES);
               end
            end
         end
         ST_RSP: begin
            n.rsp_valid = 1'b1;
            n.rcnt = r.rcnt + 8'h01;
            if (r.op == OP_HIST_RD) begin
               n.rsp_data = (r.rcnt == 8'h00) ? r.hcnt : rword[8*ridx[1:0] +: 8];
            end else begin
               case (r.rcnt)
                  8'h00:   n.rsp_data = {3'h0, r.caps};
                  8'h01:   n.rsp_data = r.rate[7:0];
                  default: n.rsp_data = r.rate[15:8];
               endcase
            end
            if (r.rcnt == rlen - 8'h01) begin
               n.st = ST_IDLE;
            end
         end
         default: begin
         end
      endcase
      // Faults log last so they survive a clear in the same cycle
      if (selftest_fault_i) begin
         n = log_err(n, CAT_SELFTEST, ERR_SELFTEST, 16'h0000);
      end
      if (op_fault_i) begin
         n = log_err(n, CAT_OPER, ERR_OPER, 16'h0000);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
         r.rd_instr <= FL_FAST;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // Outputs
   always_comb begin
      s1 = 8'h00;
      s1[STS_RIP] = r.rip;
      s1[STS_RDAV] = (r.st == ST_RSP);
   end

   assign link.cmd_ready = (r.st == ST_IDLE) || (r.st == ST_RX);
   assign link.rsp_valid = r.rsp_valid;
   assign link.rsp_data = r.rsp_data;
   assign link.status1 = s1;
   assign link.status_err = {r.errf, r.ecode};
   assign fl_start_o = r.fl_start;
   assign fl_op_o = r.fl_op;
   assign fl_addr_o = r.addr;
   assign fl_wvalid_o = r.wvalid;
   assign fl_wdata_o = r.wdata;
   assign fl_rd_instr_o = r.rd_instr;
   assign fl_clk_limit_o = r.rate;

endmodule

// *** src/bfe_host.sv ***
// Host end: AXI4-Lite controlled command sender for the boot link
`timescale 1ns/100ps
module bfe_host (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Interrupt
   output logic             irq_o,
   // Command link
   bfe_link_if.host         link
);
   import bfe_pkg::*;

   typedef struct packed {
      logic        aw_ok;
      logic [7:0]  awa;
      logic        w_ok;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
      logic [31:0] cmd;
      logic [31:0] param;
      logic        busy;
      logic [2:0]  idx;
      logic [8:0]  pcnt;
      logic        rx_valid;
      logic [7:0]  rx_data;
      logic [3:0]  irq;
      logic [3:0]  mask;
      logic        rip_d;
   } bfe_host_s;

   bfe_host_s  r;
   bfe_host_s  n;
   logic       sop;
   logic       sig;
   logic       opph;
   logic       mp;
   logic       pg;
   logic       done;
   logic [2:0] nbe;
   logic [2:0] j;
   logic [8:0] pa;
   logic [7:0] pb;
   logic [7:0] cbyte;
   logic [7:0] wa;
   logic       rip;

   // ==========================================================
   // Byte sequencer
   always_comb begin
      sop = r.cmd[CMD_SOP];
      sig = r.cmd[CMD_SIG];
      pg = (r.cmd[7:0] == OP_PAGE);
      nbe = sig ? 3'h4 : r.cmd[CMD_NB_LO +: 3];
      opph = sop && (r.idx == 3'h0);
      j = r.idx - {2'h0, sop};
      mp = !opph && (j < nbe);
      pa = opph ? 9'h000 : r.pcnt + 9'h001;
      pb = r.param[8*j[1:0] +: 8];
      if (r.cmd[7:0] == OP_RATE_WR && j == 3'h0) begin
         pb = pb & CAPS_MASK;
      end
      cbyte = opph ? r.cmd[7:0] : mp ? (sig ? SIG_WORD[8*j[1:0] +: 8] : pb) : PAD_BYTE;
      // A last page segment keeps going with pad bytes up to a full page
      done = (opph ? (nbe == 3'h0) : (j + 3'h1 >= nbe))
             && (!pg || !r.cmd[CMD_LAST] || pa == PAGE_BYTES);
   end

   assign rip = link.status1[STS_RIP];
   assign wa = {r.awa[7:2], 2'h0};

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      if (s_awvalid && !r.aw_ok) begin
         n.aw_ok = 1'b1;
         n.awa = s_awaddr;
      end
      if (s_wvalid && !r.w_ok) begin
         n.w_ok = 1'b1;
         n.wd = s_wdata;
         n.ws = s_wstrb;
      end
      if (r.bvalid && s_bready) begin
         n.bvalid = 1'b0;
      end
      if (r.aw_ok && r.w_ok && !r.bvalid) begin
         n.aw_ok = 1'b0;
         n.w_ok = 1'b0;
         n.bvalid = 1'b1;
         case (wa)
            REG_CMD: begin
               if (r.busy || (r.wd[7:0] == OP_PAGE && r.wd[CMD_SOP] && rip)
                   || (!r.wd[CMD_SIG] && r.wd[CMD_NB_LO +: 3] > 3'h4)) begin
                  n.irq[IRQ_REFUS] = 1'b1;
               end else begin
                  n.cmd = r.wd;
                  n.busy = 1'b1;
                  n.idx = 3'h0;
               end
            end
            REG_PARAM: begin
               for (int b = 0; b < 4; b++) begin
                  if (r.ws[b]) begin
                     n.param[8*b +: 8] = r.wd[8*b +: 8];
                  end
               end
            end
            REG_IRQ:  n.irq = r.irq & ~r.wd[3:0];
            REG_MASK: n.mask = r.wd[3:0];
            default: begin
            end
         endcase
      end
      if (r.rvalid && s_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_arvalid && !r.rvalid) begin
         n.rvalid = 1'b1;
         case ({s_araddr[7:2], 2'h0})
            REG_CMD:   n.rdata = r.cmd;
            REG_PARAM: n.rdata = r.param;
            REG_STAT:  n.rdata = {link.status_err, link.status1, 7'h00, r.busy};
            REG_RX: begin
               n.rdata = {23'h000000, r.rx_valid, r.rx_data};
               n.rx_valid = 1'b0;
            end
            REG_IRQ:   n.rdata = {28'h0000000, r.irq};
            REG_MASK:  n.rdata = {28'h0000000, r.mask};
            default:   n.rdata = 32'h00000000;
         endcase
      end
      // Events come after clears so a set in the same cycle wins
      if (r.busy && link.cmd_ready) begin
         n.pcnt = pa;
         if (done) begin
            n.busy = 1'b0;
            n.irq[IRQ_SENT] = 1'b1;
         end else if (opph || mp) begin
            n.idx = r.idx + 3'h1;
         end
      end
      if (link.rsp_valid) begin
         n.rx_valid = 1'b1;
         n.rx_data = link.rsp_data;
         n.irq[IRQ_RX] = 1'b1;
      end
      n.rip_d = rip;
      if (r.rip_d && !rip) begin
         n.irq[IRQ_RIPDN] = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // Outputs
   assign s_awready = !r.aw_ok;
   assign s_wready = !r.w_ok;
   assign s_bvalid = r.bvalid;
   assign s_bresp = 2'h0;
   assign s_arready = !r.rvalid;
   assign s_rvalid = r.rvalid;
   assign s_rdata = r.rdata;
   assign s_rresp = 2'h0;
   assign irq_o = |(r.irq & r.mask);
   assign link.cmd_valid = r.busy;
   assign link.cmd_first = opph;
   assign link.cmd_last = r.cmd[CMD_LAST] && done;
   assign link.cmd_data = cbyte;

endmodule

// *** tb/bfe_asserts.sv ***
// Link checker for the host and device ends
`timescale 1ns/100ps
module bfe_asserts (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // Link
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic        cmd_first,
   input wire logic        cmd_last,
   input wire logic [7:0]  cmd_data,
   input wire logic        rsp_valid,
   input wire logic [7:0]  rsp_data,
   input wire logic [7:0]  status1,
   input wire logic [15:0] status_err
);
   import bfe_pkg::*;
   // ==========================================================
   // Tracks op-code and signature; first byte resets it
   logic [7:0]  op_r;
   logic [23:0] sh_r;
   wire         tk  = cmd_valid && cmd_ready;
   wire  [7:0]  op  = cmd_first ? cmd_data : op_r;
   wire         fin = tk && cmd_last;
   wire         sok = !cmd_first && {cmd_data, sh_r} == SIG_WORD;
   wire         sgn = op == OP_CLR_STAT || op == OP_CLR_HIST || op == OP_ERASE;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         op_r <= 8'h00;
         sh_r <= 24'h000000;
      end else if (tk) begin
         op_r <= op;
         sh_r <= cmd_first ? 24'h000000 : {cmd_data, sh_r[23:8]};
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // Assertions
   a_status_bits: assert property (status1[7:4] == 4'h0 && !status1[2] && !status1[0])
      else $error("stray status1 bits");
   a_rsp_flag: assert property (rsp_valid |-> $past(status1[STS_RDAV] && !cmd_ready))
      else $error("response without flag");
   a_clr_stat: assert property (fin && sok && op == OP_CLR_STAT |=> status_err == 16'h0)
      else $error("status errors kept");
   a_clr_hist: assert property (fin && sok && op == OP_CLR_HIST |=> status_err == 16'h0)
      else $error("history clear kept flags");
   a_erase_busy: assert property (fin && sok && op == OP_ERASE |=> status1[STS_RIP])
      else $error("erase not busy");
   a_page_busy: assert property (fin && op == OP_PAGE |=> status1[STS_RIP])
      else $error("page not busy");
   a_verify_busy: assert property (fin && op == OP_VERIFY |=> status1[STS_RIP])
      else $error("verify not busy");
   a_bad_sig: assert property (fin && !sok && sgn |=> status_err[13] && !status1[STS_RIP])
      else $error("bad signature acted");
   a_rate_reply: assert property (fin && op == OP_RATE_RD |=>
      ##1 rsp_valid && rsp_data[7:5] == 3'h0 ##1 rsp_valid ##1 rsp_valid)
      else $error("rate reply wrong");
   a_hist_reply: assert property (fin && op == OP_HIST_RD |=> ##1 rsp_valid [*8])
      else $error("history reply broken");
   c_erase: cover property (fin && sok && op == OP_ERASE);
   c_page: cover property (fin && op == OP_PAGE);
   c_hist: cover property (fin && op == OP_HIST_RD);
endmodule

// *** tb/tb_boot_flash_error_commands.sv ***
// Bench for host and device ends joined by the link
`timescale 1ns/100ps
module tb_boot_flash_error_commands;
   import bfe_pkg::*;
   // ==========================================================
   // Signals
   logic        clk_i, awready, wready, bvalid, arready, rvalid, irq_o, fl_start_o, fl_wvalid_o;
   logic        rst_n_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, fl_done_i = 1'b0, fl_fail_i = 1'b0;
   logic        fail_q = 1'b0, st_f = 1'b0, op_f = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, fl_wdata_o, fl_rd_instr_o;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic [1:0]  bresp, rresp;
   logic [23:0] fl_addr_o;
   logic [15:0] fl_clk_limit_o;
   logic [3:0]  dly = 4'h0;
   logic [7:0]  rq[$];
   logic [7:0]  caps [5] = '{8'hE1, 8'h02, 8'h04, 8'h08, 8'hF0};
   logic [7:0]  ins [5] = '{FL_FAST, FL_DUAL_O, FL_DUAL_IO, FL_QUAD_O, FL_QUAD_IO};
   bfe_flop_e   fl_op_o;
   int          num_errors = 0, n_checks = 0, nw, nbad, i;
   bfe_link_if u_bfe_link_if (.clk_i(clk_i));
   bfe_host u_bfe_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
      .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
      .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
      .irq_o(irq_o), .link(u_bfe_link_if));
   bfe_dev #(.ADDR_W(24)) u_bfe_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(u_bfe_link_if),
      .fl_start_o(fl_start_o), .fl_op_o(fl_op_o), .fl_addr_o(fl_addr_o),
      .fl_wvalid_o(fl_wvalid_o), .fl_wdata_o(fl_wdata_o), .fl_done_i(fl_done_i),
      .fl_fail_i(fl_fail_i), .fl_rd_instr_o(fl_rd_instr_o), .fl_clk_limit_o(fl_clk_limit_o),
      .selftest_fault_i(st_f), .op_fault_i(op_f));
   bfe_asserts u_bfe_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cmd_valid(u_bfe_link_if.cmd_valid), .cmd_ready(u_bfe_link_if.cmd_ready),
      .cmd_first(u_bfe_link_if.cmd_first), .cmd_last(u_bfe_link_if.cmd_last),
      .cmd_data(u_bfe_link_if.cmd_data), .rsp_valid(u_bfe_link_if.rsp_valid),
      .rsp_data(u_bfe_link_if.rsp_data), .status1(u_bfe_link_if.status1),
      .status_err(u_bfe_link_if.status_err));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ==========================================================
   // Flash engine stand-in: answers each job after a short delay
   always @(posedge clk_i) begin
      if (fl_start_o) dly <= 4'h9;
      else if (dly != 4'h0) dly <= dly - 4'h1;
      fl_done_i <= (dly == 4'h1) && !fl_start_o;
      fl_fail_i <= fail_q;
      if (fl_wvalid_o) nw++;
      if (fl_wvalid_o && fl_wdata_o !== PAD_BYTE) nbad++;
      if (u_bfe_link_if.rsp_valid) rq.push_back(u_bfe_link_if.rsp_data);
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic to_err;
      num_errors++;
      end_of_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 99) to_err();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 99; n++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
         d = rdata;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 99) to_err();
   endtask
   // Waits past the busy rise, then until sending and job are both over
   task automatic send(input logic [31:0] p, input logic [31:0] c);
      int n;
      wr(REG_PARAM, p);
      wr(REG_CMD, c);
      repeat (3) @(posedge clk_i);
      for (n = 0; n < 999; n++) begin
         rd(REG_STAT, s);
         if (s[0] === 1'b0 && s[9] === 1'b0) break;
      end
      if (n == 999) to_err();
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(REG_STAT, s);
      chk(s, 32'h0);
      rd(8'h40, s);
      chk(s, 32'h0);
      wr(REG_MASK, 32'h4);
      for (i = 0; i < 5; i++) begin
         send({8'h00, 8'h13, 8'hA1, caps[i]}, 32'h000303E3);
         chk(fl_rd_instr_o, ins[i]);
      end
      chk(fl_clk_limit_o, 16'h13A1);
      rq.delete();
      send(32'h0, 32'h000300E4);
      repeat (6) @(posedge clk_i);
      chk({rq.size(), rq[0], rq[1], rq[2]}, {32'd3, 24'h10A113});
      send(32'hDDCCBBAB, 32'h000304E0);
      rd(REG_STAT, s);
      chk({s[31:16], 6'h0, fl_op_o}, {CAT_CMD, 1'b0, ERR_SIG, 8'h00});
      send(32'h0, 32'h000704C2);
      rd(REG_STAT, s);
      chk(s[31:16], 16'h0);
      send(32'h0, 32'h000704E0);
      rd(REG_IRQ, s);
      chk({s[2], irq_o, fl_op_o, fl_addr_o}, {2'b11, FL_ERASE, 24'h0});
      wr(REG_IRQ, 32'hF);
      @(posedge clk_i);
      chk(irq_o, 1'b0);
      for (i = 1; i < 3; i++) begin
         nw = 0;
         nbad = 0;
         send(32'h0, 32'h000300E1);
         chk({nw[15:0], nbad[7:0], fl_addr_o}, {16'h0100, 8'h00, 24'(i * 256)});
      end
      fail_q <= 1'b1;
      send(32'h0, 32'h000300E2);
      rd(REG_STAT, s);
      chk({s[31:16], 6'h0, fl_op_o}, {CAT_CMD, 1'b0, ERR_FLASH, 6'h0, FL_VERIFY});
      fail_q <= 1'b0;
      send(32'h0, 32'h000704C3);
      rd(REG_STAT, s);
      chk(s[31:16], 16'h0);
      st_f <= 1'b1;
      @(posedge clk_i);
      st_f <= 1'b0;
      op_f <= 1'b1;
      @(posedge clk_i);
      op_f <= 1'b0;
      rq.delete();
      send(32'h0, 32'h000300C1);
      repeat (260) @(posedge clk_i);
      chk(rq.size(), 249);
      chk({rq[0], rq[3], rq[4], rq[7], rq[8], rq[248]}, 48'h020580064000);
      end_of_test();
   end
endmodule
